// ==== sim/pdc_clock_config_sva.sv ====
// checker: port assertions for the clock configuration block
module pdc_clock_config_sva (
	input logic       clk_i,
	input logic       arst_n_i,
	input logic       s_axi_bvalid,
	input logic       s_axi_rvalid,
	input logic [31:0] s_axi_rdata,
	input logic       synth_enable_i,
	input logic       divided_clock_select_i,
	input logic       low_power_exit_i,
	input logic [4:0] synth_multiplier_o,
	input logic       synth_halve_select_o,
	input logic       clk_route_halved_o,
	input logic       clk_route_divided_o,
	input logic       processor_clock_halt_o,
	input logic       divided_clock_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic       div_q;
	logic [7:0] half_cnt;
	wire        div_tog = divided_clock_o != div_q;
	// cycles since the last divided clock edge
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			div_q <= 1'h0;
			half_cnt <= 8'h00;
		end else begin
			div_q <= divided_clock_o;
			half_cnt <= div_tog ? 8'h00 : half_cnt + {7'h00, half_cnt != 8'hFF};
		end
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (!arst_n_i);
	// --------
	// properties
	// --------
	property p_mul_range; synth_multiplier_o >= 5'h02 && synth_multiplier_o <= 5'h14; endproperty
	property p_cfg_chg;
		$changed(synth_multiplier_o) || $changed(synth_halve_select_o) |-> $past(s_axi_bvalid);
	endproperty
	property p_mul_en; $changed(synth_multiplier_o) |-> !synth_enable_i; endproperty
	property p_key_rd; s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000; endproperty
	property p_halt_start; $rose(processor_clock_halt_o) |-> low_power_exit_i; endproperty
	property p_route_halved; clk_route_halved_o |-> synth_halve_select_o; endproperty
	property p_route_div; $rose(divided_clock_select_i) |-> ##[1:4] clk_route_divided_o; endproperty
	property p_div_half; div_tog |-> half_cnt <= 8'h80; endproperty
	a_mul_range: assert property (p_mul_range)
		else $error("multiplier out of range");
	a_cfg_chg: assert property (p_cfg_chg)
		else $error("multiplier changed without a write");
	a_mul_en: assert property (p_mul_en)
		else $error("multiplier changed while running");
	a_key_rd: assert property (p_key_rd)
		else $error("key bits read nonzero");
	a_halt_start: assert property (p_halt_start)
		else $error("halt without low power exit");
	a_route_halved: assert property (p_route_halved)
		else $error("halved route without halve select");
	a_route_div: assert property (p_route_div)
		else $error("divided route late");
	a_div_half: assert property (p_div_half)
		else $error("divided half period too long");
	c_halt: cover property ($rose(processor_clock_halt_o));
	c_div: cover property ($rose(clk_route_divided_o));
	c_mul: cover property ($changed(synth_multiplier_o));
endmodule // pdc_clock_config_sva

bind pdc_clock_config pdc_clock_config_sva pdc_clock_config_sva_inst (.*);

// ==== sim/testbench.sv ====
// testbench: register accesses and clock outputs of the configuration block
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_i, arst_n_i, ce_i, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic synth_enable_i, divided_clock_select_i, low_power_exit_i, synth_halve_select_o;
	logic clk_route_halved_o, clk_route_divided_o, processor_clock_halt_o, divided_clock_o;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [4:0]  synth_multiplier_o, cur;
	logic [4:0]  codes [7] = '{5'h00, 5'h01, 5'h02, 5'h05, 5'h14, 5'h15, 5'h1F};
	int          n_mismatch, compares, n;
	pdc_clock_config pdc_clock_config_inst (.*);
	initial begin
		clk_i = 1'h0;
		forever #5 clk_i = ~clk_i;
	end
	task give_verdict;
		$display("mismatches %0d compares %0d", n_mismatch, compares);
		if (n_mismatch == 0 && compares > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task tmo;
		n_mismatch++;
		$display("[ERR] %0t wait timed out", $time);
		give_verdict;
	endtask
	task wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge clk_i);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		for (n = 0; n < 40 && s_axi_bvalid !== 1'h1; n++) begin
			@(posedge clk_i);
			if (s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
			if (s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
		end
		s_axi_bready <= 1'h0;
		if (n >= 40) tmo;
	endtask
	task rd(input logic [11:0] a, input logic [31:0] e);
		@(posedge clk_i);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		for (n = 0; n < 40 && s_axi_rvalid !== 1'h1; n++) begin
			@(posedge clk_i);
			if (s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
		end
		s_axi_rready <= 1'h0;
		if (n >= 40) tmo;
		chk(s_axi_rdata, e);
	endtask
	// cycles from one sampled rise of the divided clock to the next
	task rise_div;
		for (n = 0; n < 600 && divided_clock_o !== 1'h0; n++) @(posedge clk_i);
		for (; n < 600 && divided_clock_o !== 1'h1; n++) @(posedge clk_i);
		if (n >= 600) tmo;
	endtask
	initial begin
		{arst_n_i, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
		{synth_enable_i, divided_clock_select_i, low_power_exit_i} = 3'h0;
		{ce_i, s_axi_wstrb, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 61'h1F00000000000000;
		repeat (5) @(posedge clk_i);
		arst_n_i <= 1'h1;
		rd(12'h00C, 32'h0000001F);
		rd(12'h014, 32'h000000B0);
		rd(12'h010, 32'h00000002);
		rd(12'h020, 32'h00000000);
		chk({30'h0, s_axi_rresp}, 32'h00000002);
		wr(12'h00C, 32'hACDD0003);
		rd(12'h00C, 32'h0000001F);
		wr(12'h00C, 32'hACDC0003);
		chk({30'h0, s_axi_bresp}, 32'h00000000);
		rd(12'h00C, 32'h00000003);
		repeat (3) rise_div;
		rise_div;
		chk(32'(n), 32'h00000008);
		cur = 5'h02;
		foreach (codes[i]) begin
			wr(12'h010, {16'h762D, codes[i][0], 10'h000, codes[i]});
			if (codes[i] >= 5'h02 && codes[i] <= 5'h14) cur = codes[i];
			rd(12'h010, {16'h0000, codes[i][0], 10'h000, cur});
			chk({27'h0, synth_multiplier_o}, {27'h0, cur});
			chk({31'h0, synth_halve_select_o}, {31'h0, codes[i][0]});
		end
		wr(12'h010, 32'h762C0005);
		rd(12'h010, 32'h00008014);
		chk({31'h0, clk_route_halved_o}, 32'h00000001);
		synth_enable_i <= 1'h1;
		repeat (4) @(posedge clk_i);
		rd(12'h018, 32'h00000001);
		wr(12'h010, 32'h762D0007);
		rd(12'h010, 32'h00008014);
		synth_enable_i <= 1'h0;
		wr(12'h014, 32'hDB5B0002);
		rd(12'h014, 32'h000000B0);
		wr(12'h014, 32'hDB5A0002);
		rd(12'h014, 32'h00000002);
		low_power_exit_i <= 1'h1;
		for (n = 0; n < 100 && processor_clock_halt_o !== 1'h1; n++) @(posedge clk_i);
		for (n = 0; n < 1000 && processor_clock_halt_o !== 1'h0; n++) @(posedge clk_i);
		chk(32'(n > 256 && n < 516), 32'h00000001);
		low_power_exit_i <= 1'h0;
		divided_clock_select_i <= 1'h1;
		repeat (5) @(posedge clk_i);
		chk({31'h0, clk_route_divided_o}, 32'h00000001);
		chk({31'h0, clk_route_halved_o}, 32'h00000000);
		give_verdict;
	end
endmodule // testbench

// ==== src/pdc_clock_config.v ====
// clock configuration registers with key-guarded writes over axi4-lite
`include "pdc_defines.vh"
module pdc_clock_config (
	input  wire        clk_i,
	input  wire        arst_n_i,
	input  wire        ce_i,
	input  wire [11:0] s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output reg         s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output reg         s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [11:0] s_axi_araddr,
	input  wire        s_axi_arvalid,
	output reg         s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	input  wire        synth_enable_i,
	input  wire        divided_clock_select_i,
	input  wire        low_power_exit_i,
	output reg  [4:0]  synth_multiplier_o,
	output reg         synth_halve_select_o,
	output reg         clk_route_halved_o,
	output reg         clk_route_divided_o,
	output reg         processor_clock_halt_o,
	output reg         divided_clock_o
);
	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	reg [1:0] en_sync_reg;
	reg [1:0] sel_sync_reg;
	reg [1:0] lpx_sync_reg;
	reg       lpx_prev_reg;

	always @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			en_sync_reg  <= 2'b00;
			sel_sync_reg <= 2'b00;
			lpx_sync_reg <= 2'b00;
			lpx_prev_reg <= 1'b0;
		end else if (ce_i) begin
			en_sync_reg  <= {en_sync_reg[0], synth_enable_i};
			sel_sync_reg <= {sel_sync_reg[0], divided_clock_select_i};
			lpx_sync_reg <= {lpx_sync_reg[0], low_power_exit_i};
			lpx_prev_reg <= lpx_sync_reg[1];
		end
	end

	wire synth_on = en_sync_reg[1]; // [RULE13]
	wire settle_start = lpx_sync_reg[1] & ~lpx_prev_reg;

	// ----------------------------------------
	// axi4-lite write channel
	// ----------------------------------------
	reg        aw_held_reg;
	reg        w_held_reg;
	reg [11:0] awaddr_reg;
	reg [31:0] wdata_reg;
	reg [3:0]  wstrb_reg;

	reg [6:0] divisor_reg;
	reg [4:0] mul_reg;
	reg       halve_reg;
	reg [9:0] settle_reg;

	wire        do_write = aw_held_reg & w_held_reg & ~s_axi_bvalid;
	wire [15:0] key      = wdata_reg[31:16];
	wire        full_lo  = wstrb_reg[0];
	wire        full_hi  = wstrb_reg[1];
	wire        key_ok   = wstrb_reg[2] & wstrb_reg[3];
	wire [4:0]  new_mul  = wdata_reg[4:0];
	wire        mul_ok   = (new_mul >= `PDC_MUL_MIN) && (new_mul <= `PDC_MUL_MAX);

	reg wr_mapped;
	always @* begin
		case (awaddr_reg)
			`PDC_OFS_DIV, `PDC_OFS_MUL, `PDC_OFS_SETTLE, `PDC_OFS_STATUS: wr_mapped = 1'b1;
			default: wr_mapped = 1'b0;
		endcase
	end

	always @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			aw_held_reg   <= 1'b0;
			w_held_reg    <= 1'b0;
			awaddr_reg    <= 12'h000;
			wdata_reg     <= 32'h00000000;
			wstrb_reg     <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= 2'b00;
			divisor_reg   <= `PDC_RST_DIV;
			mul_reg       <= `PDC_RST_MUL;
			halve_reg     <= 1'b0;
			settle_reg    <= `PDC_RST_SETTLE;
		end else if (ce_i) begin
			s_axi_awready <= ~aw_held_reg & ~s_axi_awready & s_axi_awvalid;
			s_axi_wready  <= ~w_held_reg & ~s_axi_wready & s_axi_wvalid;
			if (s_axi_awvalid & s_axi_awready) begin
				aw_held_reg <= 1'b1;
				awaddr_reg  <= s_axi_awaddr;
			end
			if (s_axi_wvalid & s_axi_wready) begin
				w_held_reg <= 1'b1;
				wdata_reg  <= s_axi_wdata;
				wstrb_reg  <= s_axi_wstrb;
			end
			if (do_write) begin
				aw_held_reg  <= 1'b0;
				w_held_reg   <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_mapped ? 2'b00 : 2'b10;
				// mismatched key silently leaves all fields alone [RULE15]
				case (awaddr_reg)
					`PDC_OFS_DIV: begin
						if (key_ok && key == `PDC_KEY_DIV && full_lo) // [RULE12]
							divisor_reg <= wdata_reg[6:0];
					end
					`PDC_OFS_MUL: begin
						if (key_ok && key == `PDC_KEY_MUL && !synth_on) begin // [RULE3] [RULE6]
							if (full_lo && mul_ok)
								mul_reg <= new_mul; // [RULE1]
							if (full_hi)
								halve_reg <= wdata_reg[`PDC_HALVE_BIT]; // [RULE2]
						end
					end
					`PDC_OFS_SETTLE: begin
						if (key_ok && key == `PDC_KEY_SETTLE && full_lo && full_hi) // [RULE10]
							settle_reg <= wdata_reg[9:0];
					end
					default: begin
					end
				endcase
			end
			if (s_axi_bvalid & s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	// ----------------------------------------
	// oscillator settle counter on prescaled tick
	// ----------------------------------------
	reg [7:0] pre_reg;
	reg [9:0] settle_cnt_reg;
	wire      pre_tick = (pre_reg == 8'hFF); // [RULE9]

	always @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			pre_reg                <= 8'h00;
			settle_cnt_reg         <= 10'h000;
			processor_clock_halt_o <= 1'b0;
		end else if (ce_i) begin
			pre_reg <= pre_reg + 8'h01;
			if (settle_start) begin
				settle_cnt_reg         <= settle_reg; // [RULE8]
				processor_clock_halt_o <= (settle_reg != 10'h000); // [RULE7]
			end else if (processor_clock_halt_o && pre_tick) begin
				settle_cnt_reg <= settle_cnt_reg - 10'h001;
				if (settle_cnt_reg == 10'h001)
					processor_clock_halt_o <= 1'b0; // [RULE7]
			end
		end
	end

	// ----------------------------------------
	// slow clock divider and routing
	// ----------------------------------------
	wire div_clk;

	pdc_slow_divider #(
		.W       (7),
		.RST_DIV (`PDC_RST_DIV)
	) u_div (
		.clk_i     (clk_i),
		.arst_n_i  (arst_n_i),
		.ce_i      (ce_i),
		.divisor_i (divisor_reg),
		.div_clk_o (div_clk)
	);

	always @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			synth_multiplier_o   <= `PDC_RST_MUL;
			synth_halve_select_o <= 1'b0;
			clk_route_halved_o   <= 1'b0;
			clk_route_divided_o  <= 1'b0;
			divided_clock_o      <= 1'b0;
		end else if (ce_i) begin
			synth_multiplier_o   <= mul_reg; // [RULE5]
			synth_halve_select_o <= halve_reg;
			clk_route_halved_o   <= halve_reg & ~sel_sync_reg[1]; // [RULE2]
			clk_route_divided_o  <= sel_sync_reg[1]; // [RULE14]
			divided_clock_o      <= div_clk;
		end
	end

	// ----------------------------------------
	// axi4-lite read channel, keys read as zero
	// ----------------------------------------
	always @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= 2'b00;
		end else if (ce_i) begin
			s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
			if (s_axi_arvalid & s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= 2'b00;
				case (s_axi_araddr)
					`PDC_OFS_DIV:    s_axi_rdata <= {25'h0000000, divisor_reg}; // [RULE4]
					`PDC_OFS_MUL:    s_axi_rdata <= {16'h0000, halve_reg, 10'h000, mul_reg}; // [RULE4]
					`PDC_OFS_SETTLE: s_axi_rdata <= {22'h000000, settle_reg}; // [RULE4]
					`PDC_OFS_STATUS: s_axi_rdata <= {29'h00000000, processor_clock_halt_o,
						sel_sync_reg[1], synth_on}; // [RULE13]
					default: begin
						s_axi_rdata <= 32'h00000000;
						s_axi_rresp <= 2'b10;
					end
				endcase
			end else if (s_axi_rvalid & s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end
endmodule // pdc_clock_config

// ==== src/pdc_defines.vh ====
// constants for the clock configuration block: offsets, fields, keys, reset values, timing
// How it works
// RULE1 - multiplier codes 2..20 load; 0, 1, 21..31 keep the previous multiplier
// RULE2 - bit 15 selects synthesizer clock (0) or synthesizer clock halved (1)
// RULE3 - multiplier and halving write applies only with upper key 0x762D
// RULE4 - key bits of every guarded register always read back as zero
// RULE5 - synthesizer frequency equals main clock times active multiplier
// RULE6 - multiplier register writes accepted only while synthesizer is disabled
// RULE7 - ten-bit settle count of prescaled cycles; processor clock halted while counting
// RULE8 - settle wait applies when leaving low-power mode for slow mode
// RULE9 - settle counter advances on main clock over 256; resets to 176
// RULE10 - settle count write applies only with upper key 0xDB5A
// RULE11 - divided clock is main clock over two times (divisor plus one); reset 0x1F
// RULE12 - divisor write applies only with upper key 0xACDC
// RULE13 - synthesizer enable reads 1 while running, 0 while off; gates writes
// RULE14 - divided-clock select routes divided clock instead of main or synthesizer
// RULE15 - a key mismatch changes nothing and raises no error
// RULE16 - a new divisor takes effect only at a divided-clock period boundary
`ifndef PDC_DEFINES_VH
`define PDC_DEFINES_VH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define PDC_OFS_DIV      12'h00C
`define PDC_OFS_MUL      12'h010
`define PDC_OFS_SETTLE   12'h014
`define PDC_OFS_STATUS   12'h018

// ----------------------------------------
// keys and fields
// ----------------------------------------
`define PDC_KEY_MUL      16'h762D
`define PDC_KEY_SETTLE   16'hDB5A
`define PDC_KEY_DIV      16'hACDC
`define PDC_HALVE_BIT    15
`define PDC_MUL_MIN      5'h02
`define PDC_MUL_MAX      5'h14

// ----------------------------------------
// reset values and timing
// ----------------------------------------
`define PDC_RST_DIV      7'h1F
`define PDC_RST_MUL      5'h02
`define PDC_RST_SETTLE   10'h0B0
`define PDC_PRESCALE     256

`endif

// ==== src/pdc_slow_divider.v ====
// slow clock divider: main clock over 2*(divisor+1), reload at period boundary
module pdc_slow_divider #(
	parameter W = 7,
	parameter [W-1:0] RST_DIV = 7'h1F
) (
	input  wire         clk_i,
	input  wire         arst_n_i,
	input  wire         ce_i,
	input  wire [W-1:0] divisor_i,
	output reg          div_clk_o
);
	reg [W-1:0] cnt_reg;
	reg [W-1:0] active_reg;

	always @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			cnt_reg    <= {W{1'b0}};
			active_reg <= RST_DIV; // [RULE11]
			div_clk_o  <= 1'b0;
		end else if (ce_i) begin
			if (cnt_reg == active_reg) begin
				cnt_reg   <= {W{1'b0}};
				div_clk_o <= ~div_clk_o; // [RULE11]
				// new divisor only at the end of a full period
				if (div_clk_o)
					active_reg <= divisor_i; // [RULE16]
			end else begin
				cnt_reg <= cnt_reg + 1'b1;
			end
		end
	end
endmodule // pdc_slow_divider
